// ==== logic/nfh_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfh_host #(
  parameter int FIFO_DEPTH  = 16,
  parameter int TIMEOUT_CYC = nfh_pkg::BUSY_TIMEOUT_CYC
) (
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  input  wire logic                           clk_en,
  input  wire logic                           start,
  input  wire nfh_pkg::nfh_op_t               op,
  input  wire logic [nfh_pkg::COL_W-1:0]      col_addr,
  input  wire logic [nfh_pkg::ROW_W-1:0]      row_addr,
  input  wire logic [12:0]                    xfer_len,
  input  wire logic                           allow_program,
  output logic                                busy,
  output logic                                done,
  output logic                                timeout_err,
  input  wire logic [7:0]                     wr_data,
  input  wire logic                           wr_valid,
  output logic                                wr_ready,
  output logic      [7:0]                     rd_data,
  output logic                                rd_valid,
  input  wire logic                           rd_ready,
  output logic                                cmd_latch,
  output logic                                addr_latch,
  output logic                                chip_sel_n,
  output logic                                write_strobe_n,
  output logic                                read_strobe_n,
  output logic                                write_prot_n,
  output logic      [7:0]                     byte_port_o,
  output logic                                byte_port_oe,
  input  wire logic [7:0]                     byte_port_i,
  input  wire logic                           ready_busy_n
);
  if (TIMEOUT_CYC < 1 || FIFO_DEPTH < 2) begin : g_bad
    $error("nfh_host: TIMEOUT_CYC and FIFO_DEPTH out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, ST_SETUP = 4'h1, ST_CMD1 = 4'h2, ST_ADDR = 4'h3,
    ST_WDATA = 4'h4, ST_CMD2  = 4'h5, ST_WB   = 4'h6, ST_WAIT = 4'h7,
    ST_GAP   = 4'h8, ST_READ  = 4'h9, ST_END  = 4'ha
  } nfh_state_t;

  localparam logic [4:0] W_END = nfh_pkg::WE_LOW_CYC + nfh_pkg::WE_HIGH_CYC;
  localparam logic [4:0] R_END = nfh_pkg::RE_LOW_CYC + nfh_pkg::RE_HIGH_CYC;

  function automatic logic [7:0] first_cmd(input nfh_pkg::nfh_op_t o);
    unique case (o)
      nfh_pkg::OP_READ:   return nfh_pkg::CMD_READ1;
      nfh_pkg::OP_PROG:   return nfh_pkg::CMD_PROG1;
      nfh_pkg::OP_ERASE:  return nfh_pkg::CMD_ERASE1;
      nfh_pkg::OP_STATUS: return nfh_pkg::CMD_STATUS;
      nfh_pkg::OP_COLCHG: return nfh_pkg::CMD_COL1;
      default:            return nfh_pkg::CMD_RESET;
    endcase
  endfunction : first_cmd

  function automatic logic [7:0] second_cmd(input nfh_pkg::nfh_op_t o);
    unique case (o)
      nfh_pkg::OP_READ:   return nfh_pkg::CMD_READ2;
      nfh_pkg::OP_ERASE:  return nfh_pkg::CMD_ERASE2;
      nfh_pkg::OP_COLCHG: return nfh_pkg::CMD_COL2;
      default:            return nfh_pkg::CMD_PROG2;
    endcase
  endfunction : second_cmd

  function automatic logic exempt(input nfh_pkg::nfh_op_t o);
    return o == nfh_pkg::OP_STATUS || o == nfh_pkg::OP_RESET;
  endfunction : exempt

  function automatic logic [7:0] addr_byte(input logic [2:0] idx,
      input logic [nfh_pkg::COL_W-1:0] c, input logic [nfh_pkg::ROW_W-1:0] r);
    unique case (idx)
      3'h0:    return c[7:0];
      3'h1:    return {3'h0, c[12:8]};
      3'h2:    return r[7:0];
      3'h3:    return r[15:8];
      default: return {7'h00, r[16]};
    endcase
  endfunction : addr_byte

  nfh_state_t                  state_r, state_nxt;
  nfh_pkg::nfh_op_t            op_r, op_nxt;
  logic [4:0]                  cnt_r, cnt_nxt;
  logic [31:0]                 tmo_r, tmo_nxt;
  logic [2:0]                  idx_r, idx_nxt;
  logic [12:0]                 left_r, left_nxt;
  logic [nfh_pkg::COL_W-1:0]   col_r, col_nxt;
  logic [nfh_pkg::ROW_W-1:0]   row_r, row_nxt;
  logic [7:0]                  byte_r, byte_nxt;
  logic [7:0]                  cap_r, cap_nxt;
  logic                        push_r, push_nxt;
  logic                        done_r, done_nxt;
  logic                        err_r, err_nxt;
  logic                        wp_n_r, wp_n_nxt;
  logic                        we_n_r, we_n_nxt, re_n_r, re_n_nxt;
  logic                        cle_r, cle_nxt, ale_r, ale_nxt;
  logic                        ce_n_r, ce_n_nxt, oe_r, oe_nxt;
  logic                        fifo_ready;
  logic                        wslot_end, wstate;

  nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (push_r),
    .in_ready  (fifo_ready),
    .in_data   (cap_r),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign wr_ready = state_r == ST_WDATA && cnt_r == 5'h00 && clk_en;
  assign wslot_end = cnt_r == W_END;

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    cnt_nxt   = cnt_r + 5'h01;
    tmo_nxt   = tmo_r;
    idx_nxt   = idx_r;
    left_nxt  = left_r;
    col_nxt   = col_r;
    row_nxt   = row_r;
    byte_nxt  = byte_r;
    cap_nxt   = cap_r;
    push_nxt  = 1'b0;
    done_nxt  = 1'b0;
    err_nxt   = err_r;
    wp_n_nxt  = allow_program;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = 5'h00;
        if (start) begin
          state_nxt = ST_SETUP;
          op_nxt    = op;
          col_nxt   = col_addr;
          row_nxt   = row_addr;
          left_nxt  = (op == nfh_pkg::OP_STATUS || xfer_len == 13'h0000)
                      ? 13'h0001 : xfer_len;
          err_nxt   = 1'b0;
          tmo_nxt   = '0;
        end
      end
      ST_SETUP: begin
        if (cnt_r >= nfh_pkg::CS_CYC) begin
          cnt_nxt = cnt_r;
          if (exempt(op_r) || ready_busy_n) begin
            state_nxt = ST_CMD1;
            cnt_nxt   = 5'h00;
            byte_nxt  = first_cmd(op_r);
          end else if (tmo_r >= 32'(TIMEOUT_CYC)) begin
            state_nxt = ST_END;
            cnt_nxt   = 5'h00;
            err_nxt   = 1'b1;
          end else begin
            tmo_nxt = tmo_r + 32'h1;
          end
        end
      end
      ST_CMD1: begin
        if (wslot_end) begin
          cnt_nxt = 5'h00;
          if (op_r == nfh_pkg::OP_STATUS) begin
            state_nxt = ST_GAP;
          end else if (op_r == nfh_pkg::OP_RESET) begin
            state_nxt = ST_WB;
          end else begin
            state_nxt = ST_ADDR;
            idx_nxt = (op_r == nfh_pkg::OP_ERASE) ? nfh_pkg::ADDR_ROW_IDX
                                                 : 3'h0;
            byte_nxt = addr_byte(idx_nxt, col_r, row_r);
          end
        end
      end
      ST_ADDR: begin
        if (wslot_end) begin
          cnt_nxt = 5'h00;
          if (idx_r == nfh_pkg::ADDR_LAST_IDX ||
              (op_r == nfh_pkg::OP_COLCHG &&
               idx_r == nfh_pkg::ADDR_COL_LAST)) begin
            state_nxt = (op_r == nfh_pkg::OP_PROG) ? ST_WDATA : ST_CMD2;
            byte_nxt  = second_cmd(op_r);
          end else begin
            idx_nxt  = idx_r + 3'h1;
            byte_nxt = addr_byte(idx_nxt, col_r, row_r);
          end
        end
      end
      ST_WDATA: begin
        if (cnt_r == 5'h00) begin
          cnt_nxt = wr_valid ? 5'h01 : 5'h00;
          if (wr_valid) begin
            byte_nxt = wr_data;
          end
        end else if (wslot_end) begin
          cnt_nxt = 5'h00;
          if (left_r == 13'h0001) begin
            // Programming always closes with the plain confirm byte.
            state_nxt = ST_CMD2;
            byte_nxt  = nfh_pkg::CMD_PROG2;
          end else begin
            left_nxt = left_r - 13'h0001;
          end
        end
      end
      ST_CMD2: begin
        if (wslot_end) begin
          cnt_nxt   = 5'h00;
          tmo_nxt   = '0;
          state_nxt = (op_r == nfh_pkg::OP_COLCHG) ? ST_GAP : ST_WB;
        end
      end
      ST_WB: begin
        if (cnt_r == nfh_pkg::WB_CYC) begin
          state_nxt = ST_WAIT;
          cnt_nxt   = 5'h00;
        end
      end
      ST_WAIT: begin
        cnt_nxt = 5'h00;
        if (ready_busy_n) begin
          state_nxt = (op_r == nfh_pkg::OP_READ) ? ST_GAP : ST_END;
        end else if (tmo_r >= 32'(TIMEOUT_CYC)) begin
          state_nxt = ST_END;
          err_nxt   = 1'b1;
        end else begin
          tmo_nxt = tmo_r + 32'h1;
        end
      end
      ST_GAP: begin
        if (cnt_r == nfh_pkg::WHR_CYC) begin
          state_nxt = ST_READ;
          cnt_nxt   = 5'h00;
        end
      end
      ST_READ: begin
        if (cnt_r == 5'h00 && !fifo_ready) begin
          cnt_nxt = 5'h00;
        end else if (cnt_r == nfh_pkg::RE_LOW_CYC) begin
          cap_nxt  = byte_port_i;
          push_nxt = 1'b1;
        end else if (cnt_r == R_END) begin
          cnt_nxt = 5'h00;
          if (left_r == 13'h0001) begin
            state_nxt = ST_END;
          end else begin
            left_nxt = left_r - 13'h0001;
          end
        end
      end
      ST_END: begin
        if (cnt_r == nfh_pkg::RHW_CYC) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    wstate   = state_nxt inside {ST_CMD1, ST_ADDR, ST_WDATA, ST_CMD2};
    // Strobes stay high outside their own states, so busy waits are quiet.
    we_n_nxt = !(wstate && cnt_nxt >= 5'h01 &&
                 cnt_nxt <= nfh_pkg::WE_LOW_CYC);
    re_n_nxt = !(state_nxt == ST_READ && cnt_nxt >= 5'h01 &&
                 cnt_nxt <= nfh_pkg::RE_LOW_CYC);
    cle_nxt  = state_nxt == ST_CMD1 || state_nxt == ST_CMD2;
    ale_nxt  = state_nxt == ST_ADDR;
    oe_nxt   = wstate;
    ce_n_nxt = state_nxt == ST_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      op_r    <= nfh_pkg::OP_RESET;
      cnt_r   <= 5'h00;
      tmo_r   <= '0;
      idx_r   <= 3'h0;
      left_r  <= 13'h0000;
      col_r   <= '0;
      row_r   <= '0;
      byte_r  <= 8'h00;
      cap_r   <= 8'h00;
      push_r  <= 1'b0;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      wp_n_r  <= 1'b0;
      we_n_r  <= 1'b1;
      re_n_r  <= 1'b1;
      cle_r   <= 1'b0;
      ale_r   <= 1'b0;
      ce_n_r  <= 1'b1;
      oe_r    <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      tmo_r   <= tmo_nxt;
      idx_r   <= idx_nxt;
      left_r  <= left_nxt;
      col_r   <= col_nxt;
      row_r   <= row_nxt;
      byte_r  <= byte_nxt;
      cap_r   <= cap_nxt;
      push_r  <= push_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      wp_n_r  <= wp_n_nxt;
      we_n_r  <= we_n_nxt;
      re_n_r  <= re_n_nxt;
      cle_r   <= cle_nxt;
      ale_r   <= ale_nxt;
      ce_n_r  <= ce_n_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign busy           = state_r != ST_IDLE;
  assign done           = done_r;
  assign timeout_err    = err_r;
  assign cmd_latch      = cle_r;
  assign addr_latch     = ale_r;
  assign chip_sel_n     = ce_n_r;
  assign write_strobe_n = we_n_r;
  assign read_strobe_n  = re_n_r;
  assign write_prot_n   = wp_n_r;
  assign byte_port_o    = byte_r;
  assign byte_port_oe   = oe_r;

  logic [2:0] ale_edges_r;
  always_ff @(posedge ref_clk) begin
    if (reset || state_r == ST_IDLE) begin
      ale_edges_r <= 3'h0;
    end else if ($rose(write_strobe_n) && addr_latch) begin
      ale_edges_r <= ale_edges_r + 3'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  addr_five_cycles_a: assert property (
    $rose(write_strobe_n) && cmd_latch &&
    (byte_port_o == nfh_pkg::CMD_READ2 || byte_port_o == nfh_pkg::CMD_PROG2)
    && (op_r == nfh_pkg::OP_READ || op_r == nfh_pkg::OP_PROG)
    |-> ale_edges_r == 3'h5) else $error("address not five cycles");
  col_high_zero_a: assert property (
    addr_latch && byte_port_oe && idx_r == 3'h1 |->
    byte_port_o[7:5] == 3'h0 && byte_port_o[4:0] == col_r[12:8])
    else $error("second column byte malformed");
  row_last_byte_a: assert property (
    addr_latch && byte_port_oe && idx_r == 3'h4 |->
    byte_port_o == {7'h00, row_r[16]}) else $error("fifth address malformed");
  prog_confirm_a: assert property (
    $rose(write_strobe_n) && cmd_latch && op_r == nfh_pkg::OP_PROG &&
    ale_edges_r == 3'h5 |-> byte_port_o == nfh_pkg::CMD_PROG2)
    else $error("program not closed by 10h");
  no_cache_end_a: assert property (
    $rose(write_strobe_n) && cmd_latch |-> byte_port_o != nfh_pkg::CMD_CACHE)
    else $error("cached program end issued");
  read_confirm_a: assert property (
    $rose(write_strobe_n) && cmd_latch && byte_port_o == nfh_pkg::CMD_READ2
    |-> ##2 (!cmd_latch)[*3] ##[1:30] state_r == ST_WAIT)
    else $error("read confirm not followed by busy wait");
  col_change_a: assert property (
    $rose(write_strobe_n) && cmd_latch && op_r == nfh_pkg::OP_COLCHG &&
    byte_port_o != nfh_pkg::CMD_COL1 |->
    byte_port_o == nfh_pkg::CMD_COL2 && ale_edges_r == 3'h2)
    else $error("column change malformed");
  quiet_busy_a: assert property (
    state_r == ST_WAIT && !chip_sel_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe moved while busy");
  ready_first_a: assert property (
    $fell(write_strobe_n) && state_r == ST_CMD1 && !exempt(op_r)
    |-> $past(ready_busy_n, 2)) else $error("command issued while busy");

  read_done_c: cover property (state_r == ST_READ ##[1:200] done_r &&
                               op_r == nfh_pkg::OP_READ);
  prog_done_c: cover property (done_r && op_r == nfh_pkg::OP_PROG && !err_r);
  timeout_c: cover property (done_r && err_r);
  fifo_full_c: cover property (state_r == ST_READ && !fifo_ready);
endmodule : nfh_host
`default_nettype wire

// ==== inc/nfh_pkg.sv ====
`default_nettype none
package nfh_pkg;
  localparam int CLK_PERIOD_NS = 5;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  // Bus timing figures in ns, and erase worst case in us.
  localparam int T_WP_NS         = 12;
  localparam int T_WH_NS         = 10;
  localparam int T_CS_NS         = 20;
  localparam int T_REA_NS        = 20;
  localparam int T_REH_NS        = 10;
  localparam int T_WB_NS         = 100;
  localparam int T_WHR_NS        = 60;
  localparam int T_RHW_NS        = 30;
  localparam int T_BERASE_MAX_US = 5000;

  localparam logic [4:0] WE_LOW_CYC  = 5'(ns_to_cyc(T_WP_NS));
  localparam logic [4:0] WE_HIGH_CYC = 5'(ns_to_cyc(T_WH_NS));
  localparam logic [4:0] CS_CYC      = 5'(ns_to_cyc(T_CS_NS));
  localparam logic [4:0] RE_LOW_CYC  = 5'(ns_to_cyc(T_REA_NS) + 1);
  localparam logic [4:0] RE_HIGH_CYC = 5'(ns_to_cyc(T_REH_NS));
  localparam logic [4:0] WB_CYC      = 5'(ns_to_cyc(T_WB_NS));
  localparam logic [4:0] WHR_CYC     = 5'(ns_to_cyc(T_WHR_NS));
  localparam logic [4:0] RHW_CYC     = 5'(ns_to_cyc(T_RHW_NS));
  localparam int BUSY_TIMEOUT_CYC = T_BERASE_MAX_US * 1000 / CLK_PERIOD_NS;

  // Array geometry and address layout.
  localparam int COL_W           = 13;
  localparam int ROW_W           = 17;
  localparam int PAGE_IDX_W      = 6;
  localparam int PAGE_BYTES      = 4352;
  localparam int MAIN_BYTES      = 4096;
  localparam int SPARE_BYTES     = 256;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS          = 2048;
  localparam logic [2:0] ADDR_LAST_IDX  = 3'h4;
  localparam logic [2:0] ADDR_ROW_IDX   = 3'h2;
  localparam logic [2:0] ADDR_COL_LAST  = 3'h1;

  // Command bytes.
  localparam logic [7:0] CMD_READ1  = 8'h00;
  localparam logic [7:0] CMD_READ2  = 8'h30;
  localparam logic [7:0] CMD_COL1   = 8'h05;
  localparam logic [7:0] CMD_COL2   = 8'he0;
  localparam logic [7:0] CMD_PROG1  = 8'h80;
  localparam logic [7:0] CMD_PROG2  = 8'h10;
  localparam logic [7:0] CMD_CACHE  = 8'h15;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET  = 8'hff;

  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_PROG   = 3'h1,
    OP_ERASE  = 3'h2,
    OP_STATUS = 3'h3,
    OP_RESET  = 3'h4,
    OP_COLCHG = 3'h5
  } nfh_op_t;
endpackage : nfh_pkg
`default_nettype wire

// ==== logic/nfh_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("nfh_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      wr_ptr_nxt;
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      rd_ptr_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_comb begin
    push       = in_valid && in_ready && clk_en;
    pop        = out_valid && out_ready && clk_en;
    wr_ptr_nxt = wr_ptr_r + (AW+1)'(push);
    rd_ptr_nxt = rd_ptr_r + (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (clk_en) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      if (push) begin
        mem_r[wr_ptr_r[AW-1:0]] <= in_data;
      end
    end
  end
endmodule : nfh_fifo
`default_nettype wire

// ==== tb/nfh_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfh_flash_model #(
  parameter int T_BUSY_NS = 300
) (
  input  wire logic        cmd_latch,
  input  wire logic        addr_latch,
  input  wire logic        chip_sel_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_prot_n,
  input  wire logic [7:0]  byte_port_o,
  input  wire logic        byte_port_oe,
  input  wire logic        stuck_busy,
  output logic      [7:0]  byte_port_i,
  output logic             rb_low,
  output logic      [12:0] last_col,
  output logic      [12:0] rd_col,
  output logic      [16:0] last_row,
  output logic      [2:0]  n_addr,
  output logic             addr_bad,
  output logic      [7:0]  viol
);
  logic [7:0] mem [logic [29:0]];
  logic [7:0] pbuf [$];
  logic [7:0] ab [0:7];
  logic [7:0] dout;
  logic       stat_md;
  logic       standby;
  int         n_busy;

  // Chip select is ignored while busy, so standby also needs ready.
  assign standby = chip_sel_n && !rb_low;

  initial begin
    rb_low = 1'b0;
    n_busy = 0;
    n_addr = 3'h0;
    viol = 8'h00;
    addr_bad = 1'b0;
    stat_md = 1'b0;
    dout = 8'h00;
    byte_port_i = 8'h00;
  end

  task automatic hold_busy(input int ns);
    n_busy++;
    rb_low = 1'b1;
    #(ns);
    while (stuck_busy) #10;
    n_busy--;
    // Holds run at once and are counted, so busy spans both.
    rb_low = n_busy != 0;
  endtask : hold_busy

  always @(posedge write_strobe_n) if (!chip_sel_n) begin
    if (rb_low && !(cmd_latch && (byte_port_o == 8'h70 ||
        byte_port_o == 8'hff)))
      viol = viol + 8'h01;
    // The host must drive the port while it strobes a byte in.
    if (!byte_port_oe)
      viol = viol + 8'h01;
    if (cmd_latch) begin
      stat_md = (byte_port_o == 8'h70);
      case (byte_port_o)
        8'h00, 8'h05, 8'h60: n_addr = 3'h0;
        8'h80: begin
          n_addr = 3'h0;
          pbuf.delete();
        end
        8'h10, 8'h30: begin
          last_col = {ab[1][4:0], ab[0]};
          last_row = {ab[4][0], ab[3], ab[2]};
          addr_bad = |ab[1][7:5] || |ab[4][7:1] || last_col > 13'h10ff;
          rd_col = last_col;
          if (byte_port_o == 8'h10 && write_prot_n)
            foreach (pbuf[i]) mem[{last_row, last_col + 13'(i)}] = pbuf[i];
          fork hold_busy(T_BUSY_NS); join_none
        end
        8'he0: rd_col = {ab[1][4:0], ab[0]};
        8'hd0: begin
          last_row = {ab[2][0], ab[1], ab[0]};
          if (write_prot_n)
            foreach (mem[k]) if (k[29:19] == last_row[16:6]) mem[k] = 8'hff;
          fork hold_busy(T_BUSY_NS * 2); join_none
        end
        8'hff: fork hold_busy(T_BUSY_NS / 10); join_none
        default: ;
      endcase
    end else if (addr_latch) begin
      ab[n_addr] = byte_port_o;
      n_addr = n_addr + 3'h1;
    end else
      pbuf.push_back(byte_port_o);
  end

  // Released port lines show the inverse of the last byte.
  always @(negedge read_strobe_n) if (!chip_sel_n) begin
    if (byte_port_oe)
      viol = viol + 8'h01;
    dout = stat_md ? {write_prot_n, !rb_low, 6'h00} : 8'hff;
    if (!stat_md && mem.exists({last_row, rd_col}))
      dout = mem[{last_row, rd_col}];
    if (!stat_md)
      rd_col = rd_col + 13'h1;
    byte_port_i <= #18 dout;
  end
  always @(posedge read_strobe_n) byte_port_i <= #15 ~dout;
endmodule : nfh_flash_model
`default_nettype wire

// ==== tb/nfh_host_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfh_host_tb_top;
  logic ref_clk, reset, start, allow_program, busy, done, timeout_err;
  logic wr_valid, wr_ready, rd_valid, rd_ready, cmd_latch, addr_latch;
  logic chip_sel_n, write_strobe_n, read_strobe_n, write_prot_n;
  logic byte_port_oe, ready_busy_n, rb_low, stuck_busy, addr_bad, clk_en;
  logic [7:0]  wr_data, rd_data, byte_port_o, byte_port_i, viol;
  logic [12:0] col_addr, xfer_len, last_col, rd_col;
  logic [16:0] row_addr, last_row;
  logic [2:0]  n_addr;
  logic [7:0]  rxq [$];
  nfh_pkg::nfh_op_t op;
  int          miscompares = 0;
  int          tests_run = 0;

  nfh_host #(.TIMEOUT_CYC(200)) i_dut (
    .ref_clk, .reset, .clk_en, .start, .op, .col_addr, .row_addr,
    .xfer_len, .allow_program, .busy, .done, .timeout_err, .wr_data,
    .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready, .cmd_latch,
    .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n,
    .write_prot_n, .byte_port_o, .byte_port_oe, .byte_port_i, .ready_busy_n
  );
  nfh_flash_model i_flash (
    .cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n,
    .write_prot_n, .byte_port_o, .byte_port_oe, .stuck_busy, .byte_port_i,
    .rb_low, .last_col, .rd_col, .last_row, .n_addr, .addr_bad, .viol
  );
  // Open-drain line with its pull-up.
  assign ready_busy_n = !rb_low;

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wr_valid && wr_ready) wr_data <= wr_data + 8'h01;
    if (rd_valid && rd_ready) rxq.push_back(rd_data);
  end

  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic run_op(input nfh_pkg::nfh_op_t o, input logic [12:0] c,
                        input logic [16:0] r, input logic [12:0] n);
    int k;
    rxq.delete();
    @(posedge ref_clk);
    start <= 1'b1;
    op <= o;
    col_addr <= c;
    row_addr <= r;
    xfer_len <= n;
    @(posedge ref_clk);
    start <= 1'b0;
    for (k = 0; k < 4000 && done !== 1'b1; k++) @(negedge ref_clk);
    chk("done", 1'b1, done);
    chk("chip_sel_n", 1'b1, chip_sel_n);
  endtask : run_op

  task automatic t_prog_read();
    @(posedge ref_clk);
    wr_data <= 8'h5a;
    allow_program <= 1'b1;
    run_op(nfh_pkg::OP_PROG, 13'h10eb, 17'h1ffff, 13'h14);
    chk("last_col", 13'h10eb, last_col);
    chk("last_row", 17'h1ffff, last_row);
    chk("n_addr", 3'h5, n_addr);
    chk("addr_bad", 1'b0, addr_bad);
    @(posedge ref_clk);
    rd_ready <= 1'b0;
    fork
      run_op(nfh_pkg::OP_READ, 13'h10eb, 17'h1ffff, 13'h14);
      begin
        repeat (600) @(posedge ref_clk);
        chk("fifo_fill", 13'h10fb, rd_col);
        rd_ready <= 1'b1;
      end
    join
    for (int i = 0; i < 20; i++) chk("rd_data", 8'h5a + i, rxq[i]);
    run_op(nfh_pkg::OP_COLCHG, 13'h10fd, 17'h1ffff, 13'h2);
    chk("col_chg0", 8'h6c, rxq[0]);
    chk("col_chg1", 8'h6d, rxq[1]);
    run_op(nfh_pkg::OP_ERASE, 13'h0, 17'h1ffc0, 13'h0);
    chk("n_addr", 3'h3, n_addr);
    chk("last_row", 17'h1ffc0, last_row);
    run_op(nfh_pkg::OP_READ, 13'h10eb, 17'h1ffff, 13'h1);
    chk("erased", 8'hff, rxq[0]);
  endtask : t_prog_read

  task automatic t_protect();
    @(posedge ref_clk);
    allow_program <= 1'b0;
    run_op(nfh_pkg::OP_PROG, 13'h0, 17'h00041, 13'h2);
    chk("write_prot_n", 1'b0, write_prot_n);
    run_op(nfh_pkg::OP_READ, 13'h0, 17'h00041, 13'h2);
    chk("protected", 8'hff, rxq[1]);
    @(posedge ref_clk);
    allow_program <= 1'b1;
    run_op(nfh_pkg::OP_STATUS, 13'h0, 17'h0, 13'h1);
    chk("status", 8'hc0, rxq[0]);
  endtask : t_protect

  task automatic t_timeout();
    @(posedge ref_clk);
    stuck_busy <= 1'b1;
    run_op(nfh_pkg::OP_READ, 13'h0, 17'h0, 13'h1);
    chk("timeout_err", 1'b1, timeout_err);
    @(posedge ref_clk);
    stuck_busy <= 1'b0;
    run_op(nfh_pkg::OP_RESET, 13'h0, 17'h0, 13'h0);
    chk("timeout_err", 1'b0, timeout_err);
    chk("viol", 8'h00, viol);
  endtask : t_timeout

  task automatic t_freeze();
    fork
      run_op(nfh_pkg::OP_STATUS, 13'h0, 17'h0, 13'h1);
      begin
        repeat (8) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk("frozen_we", 1'b0, write_strobe_n);
        chk("frozen_busy", 1'b1, busy);
        clk_en <= 1'b1;
      end
    join
    chk("status", 8'hc0, rxq[0]);
  endtask : t_freeze

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    start = 1'b0;
    op = nfh_pkg::OP_READ;
    col_addr = 13'h0;
    row_addr = 17'h0;
    xfer_len = 13'h0;
    allow_program = 1'b0;
    wr_data = 8'h00;
    wr_valid = 1'b1;
    rd_ready = 1'b1;
    stuck_busy = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_prog_read();
    t_protect();
    t_timeout();
    t_freeze();
    stop_test();
  end

  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
endmodule : nfh_host_tb_top
`default_nettype wire
